// [core/rdr_refresh.sv]
// Purpose: Portrait and landscape refresh address and timing generator
// Assumes: Display buffer answers a read one cycle after mem_rd
// Notes:   APB slave with one wait-free access cycle
//
// How it works
// [RULE1] One screen region only, no split screen
// [RULE2] Default scheme width is power of two
// [RULE3] Default scheme keeps pixel clock at operating clock
// [RULE4] Alternate scheme needs operating clock twice pixel
// [RULE5] Pan two lines default, one alternate
// [RULE6] Mode 80h selects default rotated refresh
// [RULE7] Mode C0h selects alternate rotated refresh
// [RULE8] Alternate scheme halves the pixel clock
// [RULE9] Clock select divides pixel clock further
// [RULE10] Default scheme leaves blanking timing unchanged
// [RULE11] Software sets stride as width times depth
// [RULE12] Software sets start as line bytes minus one
// [RULE13] Offset zero is upper left corner
// [RULE14] Memory contents are never rotated by hardware
// [RULE15] Alternate stride is plain width in bytes
// [RULE16] Frame is total pixels times total lines
// [RULE17] Enable low means landscape, other settings ignored
// [RULE18] Rotated start address counts bytes
// [RULE19] Landscape ignores the line stride register
// [RULE20] Mode and start change at frame boundary
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps

module rdr_refresh #(
    parameter int unsigned PADDR_W = 12,
    parameter int unsigned MADDR_W = 16
) (
    input  wire logic               clk,
    input  wire logic               rst_b,
    input  wire logic               ce,
    input  wire logic [PADDR_W-1:0] paddr,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [31:0]        pwdata,
    input  wire logic [3:0]         pstrb,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    output logic      [MADDR_W-1:0] mem_addr,
    output logic                    mem_rd,
    input  wire logic [7:0]         mem_rdata,
    output logic      [7:0]         pix_data,
    output logic                    pix_valid,
    output logic                    pix_strobe,
    output logic                    line_sync,
    output logic                    frame_sync
);
    typedef struct packed {
        logic [31:0]        prdata;
        logic               pready;
        logic               pslverr;
        logic [7:0]         clock_mode;
        logic [7:0]         hblank;
        logic [7:0]         vblank;
        logic [7:0]         start_lo;
        logic [7:0]         start_hi;
        logic [7:0]         rot_mode;
        logic [7:0]         stride;
        logic [9:0]         width;
        logic [9:0]         height;
        logic [2:0]         fmt;
        rdr_pkg::rdr_phase_t phase;
        logic               sh_rot;
        logic               sh_alt;
        logic               sh_icd;
        logic [1:0]         sh_pcs;
        logic [1:0]         sh_bpp;
        logic [14:0]        sh_start;
        logic [7:0]         sh_stride;
        logic [9:0]         sh_hdp;
        logic [9:0]         sh_vdp;
        logic [7:0]         sh_hbl;
        logic [7:0]         sh_vbl;
        logic [10:0]        hcnt;
        logic [10:0]        vcnt;
        logic [2:0]         sub;
        logic [MADDR_W-1:0] addr;
        logic [MADDR_W-1:0] base;
        logic [MADDR_W-1:0] mem_addr;
        logic               mem_rd;
        logic [2:0]         sel;
        logic [2:0]         sel_d;
        logic               rd_d;
        logic [7:0]         pix_data;
        logic               pix_valid;
        logic               pix_strobe;
        logic               line_sync;
        logic               frame_sync;
        logic [7:0]         frames;
    } rdr_refresh_state_t;

    rdr_refresh_state_t s;
    rdr_refresh_state_t next_s;
    rdr_tick_if         tk();

    // ************************************************************
    // Pixel clock divider
    // ************************************************************
    // Landscape ignores the scheme and select bits; default scheme adds no divide
    assign tk.shift   = 3'({2'b00, s.sh_icd}
                        + (s.sh_rot ? {2'b00, s.sh_alt} + {1'b0, s.sh_pcs} : 3'h0)); // [RULE3] [RULE8] [RULE9] [RULE10] [RULE17]
    assign tk.restart = (s.phase == rdr_pkg::PH_OFF);

    rdr_tick_gen #(
        .CNT_W (rdr_pkg::TICK_CNT_W)
    ) rdr_tick_gen_inst (
        .clk   (clk),
        .rst_b (rst_b),
        .ce    (ce),
        .tk    (tk)
    );

    // ************************************************************
    // Register decode, refresh sequencing
    // ************************************************************
    // All state advances in one process so a frame boundary sees one consistent mapping
    always_comb
    begin
        logic [7:0]         idx;
        logic               hit;
        logic [31:0]        rd;
        logic [10:0]        htot;
        logic [10:0]        vtot;
        logic               vis;
        logic [2:0]         ppb_m1;
        logic [MADDR_W-1:0] lbytes;
        logic [14:0]        eff;
        logic [MADDR_W-1:0] first;
        logic               hot;
        idx    = paddr[9:2];
        hit    = 1'b0;
        rd     = 32'h0000_0000;
        htot   = {1'b0, s.sh_hdp} + {3'h0, s.sh_hbl};   // [RULE16]
        vtot   = {1'b0, s.sh_vdp} + {3'h0, s.sh_vbl};   // [RULE16]
        vis    = (s.hcnt < {1'b0, s.sh_hdp}) && (s.vcnt < {1'b0, s.sh_vdp});
        ppb_m1 = 3'(4'h8 >> s.sh_bpp) - 3'h1;
        lbytes = MADDR_W'(({3'h0, s.sh_hdp} << s.sh_bpp) >> 3);
        next_s = s;
        hot    = 1'b0;
        eff    = '0;
        first  = '0;

        // Read mux; unmapped or misaligned addresses answer with an error
        if (paddr[1:0] == 2'b00 && paddr[PADDR_W-1:10] == '0)
        begin
            hit = 1'b1;
            unique case (idx)
                rdr_pkg::IDX_CLOCK_MODE:   rd = {24'h0, s.clock_mode};
                rdr_pkg::IDX_HBLANK:       rd = {24'h0, s.hblank};
                rdr_pkg::IDX_VBLANK:       rd = {24'h0, s.vblank};
                rdr_pkg::IDX_START_LOW:    rd = {24'h0, s.start_lo};
                rdr_pkg::IDX_START_HIGH:   rd = {24'h0, s.start_hi};
                rdr_pkg::IDX_ROT_MODE:     rd = {24'h0, s.rot_mode};
                rdr_pkg::IDX_LINE_STRIDE:  rd = {24'h0, s.stride};
                rdr_pkg::IDX_PANEL_WIDTH:  rd = {22'h0, s.width};
                rdr_pkg::IDX_PANEL_HEIGHT: rd = {22'h0, s.height};
                rdr_pkg::IDX_PIXEL_FORMAT: rd = {29'h0, s.fmt};
                rdr_pkg::IDX_STATUS:       rd = {16'h0, s.frames, 4'h0, s.sh_alt, s.sh_rot,
                                                 (s.vcnt >= {1'b0, s.sh_vdp}), s.phase};
                default:                   hit = 1'b0;
            endcase
        end

        // Setup cycle: answer is ready in the first access cycle; ready and error stand for that cycle only
        next_s.pready  = 1'b0;
        next_s.pslverr = 1'b0;
        if (psel && !penable)
        begin
            next_s.pready  = 1'b1;
            next_s.pslverr = !hit;
            next_s.prdata  = rd;
        end

        // Write takes effect on the edge where the access completes
        if (psel && penable && s.pready && pwrite && hit && pstrb[0])
        begin
            unique case (idx)
                rdr_pkg::IDX_CLOCK_MODE:   next_s.clock_mode = pwdata[7:0];
                rdr_pkg::IDX_HBLANK:       next_s.hblank     = pwdata[7:0];
                rdr_pkg::IDX_VBLANK:       next_s.vblank     = pwdata[7:0];
                rdr_pkg::IDX_START_LOW:    next_s.start_lo   = pwdata[7:0];
                rdr_pkg::IDX_START_HIGH:   next_s.start_hi   = {1'b0, pwdata[6:0]};
                rdr_pkg::IDX_ROT_MODE:     next_s.rot_mode   = {pwdata[7:6], 4'h0, pwdata[1:0]}; // [RULE6] [RULE7]
                rdr_pkg::IDX_LINE_STRIDE:  next_s.stride     = pwdata[7:0];
                rdr_pkg::IDX_PANEL_WIDTH:  next_s.width[7:0]  = pwdata[7:0];
                rdr_pkg::IDX_PANEL_HEIGHT: next_s.height[7:0] = pwdata[7:0];
                rdr_pkg::IDX_PIXEL_FORMAT: next_s.fmt        = pwdata[2:0];
                default:                   next_s.fmt        = s.fmt;
            endcase
        end
        if (psel && penable && s.pready && pwrite && hit && pstrb[1])
        begin
            if (idx == rdr_pkg::IDX_PANEL_WIDTH)
                next_s.width[9:8] = pwdata[9:8];
            if (idx == rdr_pkg::IDX_PANEL_HEIGHT)
                next_s.height[9:8] = pwdata[9:8];
        end

        // Start address of the coming frame, from live registers
        eff = {s.start_hi[6:0], s.start_lo};
        if (s.rot_mode[rdr_pkg::ROT_EN_BIT] && !s.rot_mode[rdr_pkg::ROT_ALT_BIT])
            eff = eff & ~{7'h00, s.stride};              // [RULE5] [RULE2]
        if (s.rot_mode[rdr_pkg::ROT_EN_BIT])
            first = MADDR_W'(eff);                       // [RULE18] [RULE13]
        else
            first = MADDR_W'({eff, 1'b0});

        // Pipeline defaults
        next_s.mem_rd     = 1'b0;
        next_s.line_sync  = 1'b0;
        next_s.frame_sync = 1'b0;
        next_s.pix_strobe = tk.tick && (s.phase == rdr_pkg::PH_RUN);
        next_s.rd_d       = s.mem_rd;
        next_s.sel_d      = s.sel;

        // Pixel out one cycle after the buffer answers
        if (s.rd_d)
        begin
            next_s.pix_data  = (mem_rdata >> s.sel_d) & (8'hFF >> (4'h8 - (4'h1 << s.sh_bpp)));
            next_s.pix_valid = 1'b1;
        end
        else if (tk.tick)
        begin
            next_s.pix_valid = 1'b0;
        end

        unique case (s.phase)
            rdr_pkg::PH_OFF:
            begin
                if (s.fmt[rdr_pkg::FMT_EN_BIT])
                begin
                    next_s.phase = rdr_pkg::PH_RUN;
                    hot          = 1'b1;
                end
            end
            rdr_pkg::PH_RUN:
            begin
                if (!s.fmt[rdr_pkg::FMT_EN_BIT])
                begin
                    next_s.phase     = rdr_pkg::PH_OFF;
                    next_s.pix_valid = 1'b0;
                end
                else if (tk.tick)
                begin
                    // Fetch for this pixel; one region only, no second screen
                    if (vis)
                    begin
                        next_s.mem_rd   = 1'b1;                  // [RULE1]
                        next_s.mem_addr = s.addr;
                        if (s.sh_rot)
                        begin
                            next_s.sel  = 3'(s.sub << s.sh_bpp);
                            next_s.addr = s.addr + MADDR_W'(s.sh_stride); // [RULE11] [RULE15]
                        end
                        else
                        begin
                            next_s.sel = 3'((ppb_m1 - s.sub) << s.sh_bpp);
                            if (s.sub == ppb_m1)
                            begin
                                next_s.sub  = 3'h0;
                                next_s.addr = s.addr + MADDR_W'(1);
                            end
                            else
                            begin
                                next_s.sub = s.sub + 3'h1;
                            end
                        end
                    end
                    if (s.hcnt == htot - 11'h1)
                    begin
                        next_s.hcnt      = 11'h0;
                        next_s.line_sync = 1'b1;
                        if (s.vcnt == vtot - 11'h1)
                            hot = 1'b1;
                        else
                        begin
                            next_s.vcnt = s.vcnt + 11'h1;
                            if (s.sh_rot)
                            begin
                                // Portrait: next panel line walks one memory column left
                                if (s.sub == ppb_m1)
                                begin
                                    next_s.sub  = 3'h0;
                                    next_s.base = s.base - MADDR_W'(1);
                                    next_s.addr = s.base - MADDR_W'(1);
                                end
                                else
                                begin
                                    next_s.sub  = s.sub + 3'h1;
                                    next_s.addr = s.base;
                                end
                            end
                            else
                            begin
                                next_s.sub  = 3'h0;
                                next_s.base = s.base + lbytes;   // [RULE19]
                                next_s.addr = s.base + lbytes;
                            end
                        end
                    end
                    else
                    begin
                        next_s.hcnt = s.hcnt + 11'h1;
                    end
                end
            end
        endcase

        // Frame boundary: take the new mapping in one step
        if (hot)
        begin
            next_s.sh_rot     = s.rot_mode[rdr_pkg::ROT_EN_BIT];  // [RULE20] [RULE17]
            next_s.sh_alt     = s.rot_mode[rdr_pkg::ROT_ALT_BIT];
            next_s.sh_pcs     = s.rot_mode[1:0];
            next_s.sh_icd     = s.clock_mode[rdr_pkg::ICD_BIT];
            next_s.sh_start   = eff;
            next_s.sh_stride  = s.stride;
            next_s.sh_bpp     = s.fmt[1:0];
            next_s.sh_hdp     = s.width;
            next_s.sh_vdp     = s.height;
            next_s.sh_hbl     = s.hblank;
            next_s.sh_vbl     = s.vblank;
            next_s.hcnt       = 11'h0;
            next_s.vcnt       = 11'h0;
            next_s.sub        = 3'h0;
            next_s.base       = first;                           // [RULE14]
            next_s.addr       = first;
            next_s.frame_sync = (s.phase == rdr_pkg::PH_RUN);
            next_s.frames     = s.frames + 8'h01;
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    // Clock enable low freezes everything, including the bus answer
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            s            <= '0;
            s.clock_mode <= rdr_pkg::REG8_RESET;
            s.rot_mode   <= rdr_pkg::REG8_RESET;
            s.width      <= rdr_pkg::WIDTH_RESET;
            s.height     <= rdr_pkg::HEIGHT_RESET;
            s.phase      <= rdr_pkg::PH_OFF;
        end
        else if (ce)
        begin
            s <= next_s;
        end
    end

    // Ports straight from the state flip-flops
    assign prdata     = s.prdata;
    assign pready     = s.pready;
    assign pslverr    = s.pslverr;
    assign mem_addr   = s.mem_addr;
    assign mem_rd     = s.mem_rd;
    assign pix_data   = s.pix_data;
    assign pix_valid  = s.pix_valid;
    assign pix_strobe = s.pix_strobe;
    assign line_sync  = s.line_sync;
    assign frame_sync = s.frame_sync;

endmodule

// [core/rdr_pkg.sv]
// Purpose: Shared constants for the rotated display refresh block
// Assumes: 32-bit APB, one register per aligned word, byte address = 4 x index
// Notes:   Printed offsets are register indices, not byte addresses

package rdr_pkg;

    // ************************************************************
    // Register indices
    // ************************************************************
    localparam logic [7:0] IDX_CLOCK_MODE   = 8'h02;
    localparam logic [7:0] IDX_HBLANK       = 8'h08;
    localparam logic [7:0] IDX_VBLANK       = 8'h0A;
    localparam logic [7:0] IDX_START_LOW    = 8'h0C;
    localparam logic [7:0] IDX_START_HIGH   = 8'h0D;
    localparam logic [7:0] IDX_ROT_MODE     = 8'h1B;
    localparam logic [7:0] IDX_LINE_STRIDE  = 8'h1C;
    localparam logic [7:0] IDX_PANEL_WIDTH  = 8'h20;
    localparam logic [7:0] IDX_PANEL_HEIGHT = 8'h21;
    localparam logic [7:0] IDX_PIXEL_FORMAT = 8'h22;
    localparam logic [7:0] IDX_STATUS       = 8'h23;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int unsigned ICD_BIT      = 4;
    localparam int unsigned ROT_EN_BIT   = 7;
    localparam int unsigned ROT_ALT_BIT  = 6;
    localparam int unsigned FMT_EN_BIT   = 2;
    localparam logic [7:0]  REG8_RESET   = 8'h00;
    localparam logic [9:0]  WIDTH_RESET  = 10'h140;
    localparam logic [9:0]  HEIGHT_RESET = 10'h0F0;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_MHZ     = 50;
    localparam int unsigned MEM_LATENCY = 1;
    localparam int unsigned TICK_CNT_W  = 6;

    typedef enum logic [0:0]
    {
        PH_OFF = 1'b0,
        PH_RUN = 1'b1
    } rdr_phase_t;

endpackage

// [core/rdr_tick_if.sv]
// Purpose: Carries the pixel clock divide request and the resulting tick
// Assumes: Single clock domain
// Notes:   shift is log2 of the divide ratio
`timescale 1ns/1ps

interface rdr_tick_if;
    logic [2:0] shift;
    logic       restart;
    logic       tick;

    modport ctl (output shift, output restart, input tick);
    modport gen (input shift, input restart, output tick);
endinterface

// [core/rdr_tick_gen.sv]
// Purpose: Pixel clock enable from the operating clock, divide by 2**shift
// Assumes: shift below CNT_W
// Notes:   Tick is a one-cycle pulse from a flip-flop
`timescale 1ns/1ps

module rdr_tick_gen #(
    parameter int unsigned CNT_W = rdr_pkg::TICK_CNT_W
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic ce,
    rdr_tick_if.gen   tk
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             tick;
    } rdr_tick_state_t;

    rdr_tick_state_t s;
    rdr_tick_state_t next_s;
    logic [CNT_W-1:0] last;

    // ************************************************************
    // Divider
    // ************************************************************
    // Terminal count; shift 0 gives a tick on every cycle
    assign last = CNT_W'((1 << tk.shift) - 1);

    always_comb
    begin
        next_s      = s;
        next_s.tick = 1'b0;
        if (tk.restart)
        begin
            next_s.cnt = '0;
        end
        else if (s.cnt >= last)
        begin
            next_s.cnt  = '0;
            next_s.tick = 1'b1;
        end
        else
        begin
            next_s.cnt = s.cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            s <= '0;
        else if (ce)
            s <= next_s;
    end

    assign tk.tick = s.tick;

endmodule

// [testbench/rdr_buffer_model.sv]
// Purpose: Display buffer seen from the refresh fetch port
// Assumes: One read answer the cycle after each fetch pulse
// Notes:   Stored byte is a fixed function of the address
`timescale 1ns/1ps

module rdr_buffer_model (
    input  wire logic        clk,
    input  wire logic        mem_rd,
    input  wire logic [15:0] mem_addr,
    output logic      [7:0]  mem_rdata
);
    // ************************************************************
    // Read port
    // ************************************************************
    initial mem_rdata = 8'h00;

    // Contents come back exactly as stored; between answers the bus flips so a stale byte never looks valid
    always @(posedge clk)
    begin
        if (mem_rd)
            mem_rdata <= mem_addr[7:0] ^ 8'h5A;
        else
            mem_rdata <= ~mem_rdata;
    end
endmodule

// [testbench/rdr_refresh_chk.sv]
// Purpose: Port-level timing checks of the refresh block
// Assumes: Clock enable held high by the bench
// Notes:   Bound to every refresh block instance
`timescale 1ns/1ps

module rdr_refresh_chk #(
    parameter int unsigned MADDR_W = 16
) (
    input wire logic               clk,
    input wire logic               rst_b,
    input wire logic               ce,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire logic [MADDR_W-1:0] mem_addr,
    input wire logic               mem_rd,
    input wire logic               pix_valid,
    input wire logic               pix_strobe,
    input wire logic               line_sync,
    input wire logic               frame_sync
);
    // ************************************************************
    // Bus and stream relations
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    chk_ready_after_setup: assert property (psel && !penable && ce |=> pready)
        else $error("ready missing after setup");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_error_in_access: assert property (pslverr |-> pready && psel && penable)
        else $error("error outside access");
    chk_fetch_on_strobe: assert property (mem_rd |-> pix_strobe)
        else $error("fetch without pixel strobe");
    chk_fetch_to_pixel: assert property (mem_rd |-> ##2 pix_valid)
        else $error("fetched pixel not shown");
    chk_pixel_has_fetch: assert property ($rose(pix_valid) |-> $past(mem_rd, 2))
        else $error("pixel without fetch");
    chk_addr_hold: assert property (!mem_rd |-> $stable(mem_addr))
        else $error("address moved without fetch");
    chk_line_single: assert property (line_sync |=> !line_sync)
        else $error("line pulse too long");
    chk_reset_quiet: assert property (disable iff (1'b0) !rst_b |=> !pready && !mem_rd && !pix_valid && !frame_sync)
        else $error("output active in reset");

    cover property (pslverr);
    cover property (mem_rd ##2 pix_valid);
    cover property (frame_sync);
endmodule

bind rdr_refresh rdr_refresh_chk #(.MADDR_W(MADDR_W)) rdr_refresh_chk_inst (.clk, .rst_b, .ce, .psel, .penable,
    .pready, .pslverr, .mem_addr, .mem_rd, .pix_valid, .pix_strobe, .line_sync, .frame_sync);

// [testbench/rotated_display_refresh_test.sv]
// Purpose: Register and refresh sequence tests of the refresh block
// Assumes: 4x2 panel, 8 bpp, stride 4, blanking 2 pixels and 1 line
// Notes:   One frame is 18 pixel periods
`timescale 1ns/1ps

module rotated_display_refresh_test;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        ce = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hF;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] mem_addr;
    logic        mem_rd;
    logic [7:0]  mem_rdata;
    logic [7:0]  pix_data;
    logic        pix_valid;
    logic        pix_strobe;
    logic        line_sync;
    logic        frame_sync;
    logic [31:0] rd;
    logic        err;
    int          fail_count = 0;
    int          cmp_count = 0;
    int          cycles = 0;

    rdr_refresh rdr_refresh_inst (.clk, .rst_b, .ce, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .mem_addr, .mem_rd, .mem_rdata, .pix_data, .pix_valid, .pix_strobe, .line_sync, .frame_sync);
    rdr_buffer_model rdr_buffer_model_inst (.clk, .mem_rd, .mem_addr, .mem_rdata);

    // ************************************************************
    // Clock, timeout and helpers
    // ************************************************************
    always #10 clk = ~clk;

    // Ceiling well above the several hundred cycles the sequence needs
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            test_done();
        end
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // APB transfer; waits for ready as long as it takes, the bench timeout catches a stuck slave
    task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    // Program mode and start, then measure one whole frame after the latching frame start
    task run(input logic [7:0] mode, input logic [7:0] st, input int dv, input logic [15:0] a0, input logic [15:0] a1);
        int t;
        int t0;
        int k;
        int s0;
        int s1;
        logic [15:0] ad[2];
        logic [7:0]  pd;
        apb(1'b1, rdr_pkg::IDX_START_LOW, {24'h0, st});
        apb(1'b1, rdr_pkg::IDX_ROT_MODE, {24'h0, mode});
        t = 0;
        // Skip one whole frame so the pixel divider has settled on the new ratio
        repeat (2)
        begin
            @(posedge clk);
            while (frame_sync !== 1'b1 && t < 400)
            begin
                @(posedge clk);
                t++;
            end
        end
        {t, t0, k, s0, s1} = '0;
        pd = 8'h00;
        do
        begin
            @(posedge clk);
            t++;
            if (pix_strobe === 1'b1 && s0 == 0)
                s0 = t;
            else if (pix_strobe === 1'b1 && s1 == 0)
                s1 = t;
            if (k > 0 && t == t0 + 2)
                pd = pix_data;
            if (mem_rd === 1'b1 && k < 2)
            begin
                ad[k] = mem_addr;
                t0 = (k == 0) ? t : t0;
                k++;
            end
        end
        while (frame_sync !== 1'b1 && t < 400);
        chk(t, 18 * dv);
        chk(s1 - s0, dv);
        chk({16'h0, ad[0]}, {16'h0, a0});
        chk({16'h0, ad[1]}, {16'h0, a1});
        chk({24'h0, pd}, {24'h0, a0[7:0] ^ 8'h5A});
        apb(1'b0, rdr_pkg::IDX_STATUS, 32'h0);
        chk({30'h0, rd[3:2]}, {30'h0, mode[7] & mode[6], mode[7]});
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    logic [7:0]  ri[5] = '{8'h1B, 8'h1C, 8'h0D, 8'h20, 8'h21};
    logic [31:0] rv[5] = '{32'h0, 32'h0, 32'h0, 32'h140, 32'hF0};
    logic [7:0]  wi[8] = '{8'h20, 8'h21, 8'h08, 8'h0A, 8'h1C, 8'h0D, 8'h02, 8'h22};
    logic [31:0] wv[8] = '{32'h4, 32'h2, 32'h2, 32'h1, 32'h4, 32'h0, 32'h0, 32'h7};

    initial
    begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b0, ri[i], 32'h0);
            chk(rd, rv[i]);
        end
        apb(1'b1, rdr_pkg::IDX_ROT_MODE, 32'hFF);
        apb(1'b0, rdr_pkg::IDX_ROT_MODE, 32'h0);
        chk(rd, 32'hC3);
        apb(1'b1, rdr_pkg::IDX_START_HIGH, 32'hFF);
        apb(1'b0, rdr_pkg::IDX_START_HIGH, 32'h0);
        chk(rd, 32'h7F);
        apb(1'b0, 8'h30, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, rdr_pkg::IDX_STATUS, 32'hFF);
        chk({31'h0, err}, 32'h0);
        apb(1'b1, rdr_pkg::IDX_ROT_MODE, 32'h0);
        // Power-of-two stride of 4 bytes for a 4 pixel rotated width at 8 bpp
        for (int i = 0; i < 8; i++)
            apb(1'b1, wi[i], wv[i]);
        run(8'h00, 8'h03, 1, 16'h0006, 16'h0007);
        run(8'h80, 8'h03, 1, 16'h0003, 16'h0007);
        run(8'h80, 8'h05, 1, 16'h0001, 16'h0005);
        run(8'hC0, 8'h05, 2, 16'h0005, 16'h0009);
        run(8'hC1, 8'h03, 4, 16'h0003, 16'h0007);
        // Input divide also halves the landscape pixel rate
        apb(1'b1, rdr_pkg::IDX_CLOCK_MODE, 32'h10);
        run(8'h00, 8'h03, 2, 16'h0006, 16'h0007);
        test_done();
    end
endmodule
